// >>> src/ifc_pkg.sv
package ifc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] FACTOR_CFG_WORD_0_ADDR = 32'hFFFF_E000;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFFF_E040;
  localparam logic [31:0] IRQ_CLEAR_ADDR = 32'hFFFF_E044;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hFFFF_E048;
  localparam logic [31:0] SOFT_REQ_ADDR = 32'hFFFF_E04C;

  // ----------------------------------------------------------------
  // Field layout of one factor lane
  // ----------------------------------------------------------------
  localparam int NUM_FACTORS = 2;
  localparam int LANE_W = 8;
  localparam int LVL_LSB = 0;
  localparam int LVL_W = 3;
  localparam int DMA_TRIG_BIT = 4;
  localparam int SENSE_LSB = 5;
  localparam int SENSE_W = 2;
  localparam int SOFT_FACTOR = 0;
  localparam int PIN_FACTOR = 1;

  // Only the two implemented lanes hold bits; 7 and 3 of each lane stay zero
  localparam logic [31:0] FACTOR_CFG_WMASK = 32'h0000_7777;
  localparam logic [31:0] FACTOR_CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
  localparam logic [2:0] LEVEL_DISABLED = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Request sensing modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SENSE_LOW = 2'b00,
    SENSE_HIGH = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } ifc_sense_type;

endpackage

// >>> src/ifc_top.sv
`timescale 1ns/1ps

// How it works
// - Each factor keeps its own setting byte
// - Level code zero blocks the resolver request (status still sets), otherwise priority one-seven
// - With DMA flag, code selects channel zero-seven
// - DMA flag steers request to DMA, not the resolver; status still sets
// - Sense code: low, high, falling, rising
// - Software factor active only with sense code 00
// - Factor one from pin, factor zero software
module ifc_top #(
  parameter int DMA_CHANNELS = 8
) (
  input wire logic ref_clk, // System clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [31:0] bus_addr, // Register byte address
  input wire logic [31:0] bus_wdata, // Register write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [31:0] bus_rdata, // Read data, cycle after strobe
  input wire logic ext_irq_pin_0, // First external interrupt pin, async
  output logic [1:0] irq_req, // Per-factor request to priority resolver
  output logic [2:0] irq_lvl_f0, // Priority of factor 0 while requesting
  output logic [2:0] irq_lvl_f1, // Priority of factor 1 while requesting
  output logic [7:0] dma_start, // Per-channel DMA activation
  output logic irq_out // Level interrupt, enabled sticky status
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The 3-bit field can only name eight channels
  if (DMA_CHANNELS != 8)
  begin : g_bad_chan
    $error("ifc_top: DMA_CHANNELS must be 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] factor_cfg_reg;
  logic [1:0] stat_reg;
  logic [1:0] en_reg;
  logic soft_req_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic soft_prev_reg;
  logic [31:0] rdata_reg;
  logic [1:0] irq_req_reg;
  logic [2:0] irq_lvl_f0_reg;
  logic [2:0] irq_lvl_f1_reg;
  logic [7:0] dma_start_reg;
  logic irq_out_reg;

  // ----------------------------------------------------------------
  // Sensing decode, shared by both factors
  // ----------------------------------------------------------------
  function automatic logic sense_hit(
    input logic [1:0] sense,
    input logic cur,
    input logic prev,
    input logic soft_only
  );
    logic hit;
    hit = 1'b0;
    case (sense)
      ifc_pkg::SENSE_LOW: hit = !cur;
      ifc_pkg::SENSE_HIGH: hit = !soft_only && cur;
      ifc_pkg::SENSE_FALL: hit = !soft_only && prev && !cur;
      ifc_pkg::SENSE_RISE: hit = !soft_only && !prev && cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_cfg = bus_addr == ifc_pkg::FACTOR_CFG_WORD_0_ADDR;
  wire sel_stat = bus_addr == ifc_pkg::IRQ_STATUS_ADDR;
  wire sel_clr = bus_addr == ifc_pkg::IRQ_CLEAR_ADDR;
  wire sel_en = bus_addr == ifc_pkg::IRQ_ENABLE_ADDR;
  wire sel_soft = bus_addr == ifc_pkg::SOFT_REQ_ADDR;

  wire cfg_wr = bus_wr && sel_cfg;
  wire clr_wr = bus_wr && sel_clr;
  wire en_wr = bus_wr && sel_en;
  wire soft_wr = bus_wr && sel_soft;

  // Unused lanes and bits 7/3 of each lane are never stored
  wire [31:0] factor_cfg_next = bus_wdata & ifc_pkg::FACTOR_CFG_WMASK;

  // Clear register reads as zero; unmapped addresses read zero too
  wire [31:0] rdata_next =
    !bus_rd ? ifc_pkg::READ_ZERO :
    sel_cfg ? factor_cfg_reg :
    sel_stat ? {30'h0000_0000, stat_reg} :
    sel_en ? {30'h0000_0000, en_reg} :
    sel_soft ? {31'h0000_0000, soft_req_reg} :
    ifc_pkg::READ_ZERO;

  // ----------------------------------------------------------------
  // Per-factor request detection
  // ----------------------------------------------------------------
  // The software request bit drives an active-low internal source line,
  // so the only useful sensing mode for it is low level.
  wire [1:0] src_cur = {pin_sync_reg, !soft_req_reg};
  wire [1:0] src_prev = {pin_prev_reg, soft_prev_reg};

  logic [1:0] hit;
  logic [1:0] irq_hit;
  logic [1:0] dma_hit;
  logic [1:0] sense_sel [ifc_pkg::NUM_FACTORS];
  logic [1:0] dma_trig;
  logic [2:0] level_or_chan [ifc_pkg::NUM_FACTORS];
  logic [7:0] chan_onehot [ifc_pkg::NUM_FACTORS];

  for (genvar i = 0; i < ifc_pkg::NUM_FACTORS; i++)
  begin : g_factor
    assign sense_sel[i] = factor_cfg_reg[i*ifc_pkg::LANE_W+ifc_pkg::SENSE_LSB +: ifc_pkg::SENSE_W];
    assign dma_trig[i] = factor_cfg_reg[i*ifc_pkg::LANE_W+ifc_pkg::DMA_TRIG_BIT];
    assign level_or_chan[i] = factor_cfg_reg[i*ifc_pkg::LANE_W+ifc_pkg::LVL_LSB +: ifc_pkg::LVL_W];
    assign hit[i] = sense_hit(sense_sel[i], src_cur[i], src_prev[i], i == ifc_pkg::SOFT_FACTOR);
    // Level code zero gates the CPU request only, not DMA
    assign irq_hit[i] = hit[i] && !dma_trig[i] && (level_or_chan[i] != ifc_pkg::LEVEL_DISABLED);
    assign dma_hit[i] = hit[i] && dma_trig[i];
    assign chan_onehot[i] = dma_hit[i] ? (8'h01 << level_or_chan[i]) : 8'h00;
  end

  wire [7:0] dma_start_next = chan_onehot[0] | chan_onehot[1];
  wire [2:0] irq_lvl_f0_next = irq_hit[0] ? level_or_chan[0] : ifc_pkg::LEVEL_DISABLED;
  wire [2:0] irq_lvl_f1_next = irq_hit[1] ? level_or_chan[1] : ifc_pkg::LEVEL_DISABLED;

  // A new detection in the cycle of the clear keeps the bit set
  wire [1:0] clr_bits = clr_wr ? bus_wdata[1:0] : 2'h0;
  wire [1:0] stat_next = (stat_reg & ~clr_bits) | hit;
  wire [1:0] en_next = en_wr ? bus_wdata[1:0] : en_reg;
  wire irq_out_next = |(stat_next & en_next);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      factor_cfg_reg <= ifc_pkg::FACTOR_CFG_RESET;
      soft_req_reg <= 1'b0;
      en_reg <= ifc_pkg::IRQ_ENABLE_RESET;
    end
    else
    begin
      if (cfg_wr)
      begin
        factor_cfg_reg <= factor_cfg_next;
      end
      if (soft_wr)
      begin
        soft_req_reg <= bus_wdata[0];
      end
      en_reg <= en_next;
    end
  end

  // Pin passes two flops before any logic reads it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      soft_prev_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= ext_irq_pin_0;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      soft_prev_reg <= !soft_req_reg;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stat_reg <= ifc_pkg::IRQ_STATUS_RESET;
      irq_out_reg <= 1'b0;
      rdata_reg <= ifc_pkg::READ_ZERO;
    end
    else
    begin
      stat_reg <= stat_next;
      irq_out_reg <= irq_out_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irq_req_reg <= 2'h0;
      irq_lvl_f0_reg <= ifc_pkg::LEVEL_DISABLED;
      irq_lvl_f1_reg <= ifc_pkg::LEVEL_DISABLED;
      dma_start_reg <= 8'h00;
    end
    else
    begin
      irq_req_reg <= irq_hit;
      irq_lvl_f0_reg <= irq_lvl_f0_next;
      irq_lvl_f1_reg <= irq_lvl_f1_next;
      dma_start_reg <= dma_start_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq_req = irq_req_reg;
  assign irq_lvl_f0 = irq_lvl_f0_reg;
  assign irq_lvl_f1 = irq_lvl_f1_reg;
  assign dma_start = dma_start_reg;
  assign irq_out = irq_out_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CFG_RESERVED_ZERO: assert property (
    @(posedge ref_clk) disable iff (srst)
    (factor_cfg_reg & ~ifc_pkg::FACTOR_CFG_WMASK) == 32'h0000_0000)
    else $error("reserved configuration bits are set");

  AST_CFG_READBACK: assert property (
    @(posedge ref_clk) disable iff (srst)
    (bus_rd && sel_cfg) |=> (bus_rdata == $past(factor_cfg_reg)))
    else $error("configuration word read back wrong");

  AST_LEVEL_ZERO_OFF: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!dma_trig[1] && level_or_chan[1] == 3'h0) |=> (!irq_req[1] && irq_lvl_f1 == 3'h0))
    else $error("factor 1 requested with level zero");

  AST_LEVEL_PASSED: assert property (
    @(posedge ref_clk) disable iff (srst)
    irq_req[0] |-> (irq_lvl_f0 == $past(level_or_chan[0]) && irq_lvl_f0 != 3'h0))
    else $error("factor 0 priority does not match its setting");

  AST_CHAN_MAP: assert property (
    @(posedge ref_clk) disable iff (srst)
    dma_hit[1] |=> dma_start[$past(level_or_chan[1])])
    else $error("DMA channel selection wrong for factor 1");

  AST_DMA_NOT_CPU: assert property (
    @(posedge ref_clk) disable iff (srst)
    (dma_trig == 2'h3) |=> (irq_req == 2'h0))
    else $error("DMA-steered factor raised a CPU request");

  AST_NO_DMA_WHEN_CLEAR: assert property (
    @(posedge ref_clk) disable iff (srst)
    (dma_trig == 2'h0) |=> (dma_start == 8'h00))
    else $error("DMA started with trigger flags clear");

  AST_PIN_RISE: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sense_sel[1] == 2'b11 && !dma_trig[1] && level_or_chan[1] != 3'h0 && !pin_prev_reg && pin_sync_reg)
    |=> irq_req[1] ##1 !irq_req[1] || pin_prev_reg == pin_sync_reg)
    else $error("rising edge of pin not detected");

  AST_PIN_LOW: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!srst && sense_sel[1] == 2'b00 && !pin_sync_reg) |=> stat_reg[1])
    else $error("low level of pin not detected");

  AST_SOFT_ONLY_LOW: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sense_sel[0] != 2'b00) |=> (!irq_req[0] && (dma_start & ~$past(chan_onehot[1])) == 8'h00))
    else $error("software factor active with a nonzero sensing code");

  AST_STICKY_SET_WINS: assert property (
    @(posedge ref_clk) disable iff (srst)
    !srst |=> ((($past(stat_reg & ~clr_bits) | $past(hit)) & ~stat_reg) == 2'h0))
    else $error("status bit lost");

  AST_IRQ_OUT: assert property (
    @(posedge ref_clk) disable iff (srst)
    irq_out == |(stat_reg & en_reg))
    else $error("interrupt output disagrees with enabled status");

endmodule

// >>> tb/ifc_far_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Resolver and DMA request side, sticky capture of what arrived
// ----------------------------------------------------------------
module ifc_far_model (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic clr, // Bench clears the captures
  input wire logic [1:0] irq_req, // Requests to the resolver
  input wire logic [2:0] irq_lvl_f1, // Priority of factor 1
  input wire logic [7:0] dma_start, // Channel activations
  output logic [1:0] seen_irq, // Any request seen per factor
  output logic [2:0] got_lvl1, // Last priority seen with factor 1
  output logic [7:0] seen_dma // Any activation seen per channel
);
  // Captures are sticky so a one-cycle edge pulse is never missed
  always_ff @(posedge ref_clk)
  begin
    if (srst || clr)
    begin
      seen_irq <= 2'h0;
      got_lvl1 <= 3'h0;
      seen_dma <= 8'h00;
    end
    else
    begin
      seen_irq <= seen_irq | irq_req;
      seen_dma <= seen_dma | dma_start;
      if (irq_req[1])
      begin
        got_lvl1 <= irq_lvl_f1;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) check_count++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: %h vs %h", $time, a, b); end

module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] bus_addr = 32'h0000_0000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic pin = 1'b1;
  logic clr = 1'b0;
  logic [1:0] irq_req;
  logic [2:0] lvl0;
  logic [2:0] lvl1;
  logic [7:0] dma_start;
  logic irq_out;
  logic [1:0] seen_irq;
  logic [2:0] got_lvl1;
  logic [7:0] seen_dma;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] rd;

  always #20 ref_clk = ~ref_clk;

  ifc_top dut (.ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_irq_pin_0(pin), .irq_req(irq_req), .irq_lvl_f0(lvl0),
    .irq_lvl_f1(lvl1), .dma_start(dma_start), .irq_out(irq_out));

  ifc_far_model far (.ref_clk(ref_clk), .srst(srst), .clr(clr), .irq_req(irq_req), .irq_lvl_f1(lvl1),
    .dma_start(dma_start), .seen_irq(seen_irq), .got_lvl1(got_lvl1), .seen_dma(seen_dma));

  // ----------------------------------------------------------------
  // Bus and stimulus helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rdw(input logic [31:0] a);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata;
  endtask

  // Clear captures, then one low pulse on the pin, long enough to cross the synchroniser
  task automatic pulse_pin();
    @(posedge ref_clk);
    clr <= 1'b1;
    pin <= 1'b0;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdw(ifc_pkg::FACTOR_CFG_WORD_0_ADDR);
    `CHK(rd, 32'h0000_0000)
    wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, 32'hFFFF_FFFF);
    rdw(ifc_pkg::FACTOR_CFG_WORD_0_ADDR);
    `CHK(rd, 32'h0000_7777)
    // Read data must stand for one cycle only
    @(posedge ref_clk);
    #1;
    `CHK(bus_rdata, 32'h0000_0000)
    wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, 32'h0000_0000);
    rdw(32'hFFFF_E0F0);
    `CHK(rd, 32'h0000_0000)
    rdw(ifc_pkg::IRQ_CLEAR_ADDR);
    `CHK(rd, 32'h0000_0000)
    $display("test regs done");
  endtask

  task automatic t_levels();
    logic [2:0] lv [3] = '{3'h0, 3'h3, 3'h7};
    foreach (lv[i])
    begin
      wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, {16'h0000, 5'b01100, lv[i], 8'h00});
      pulse_pin();
      `CHK(seen_irq, {lv[i] != 3'h0, 1'b0})
      `CHK(got_lvl1, lv[i])
      `CHK(irq_req, 2'b00)
    end
    $display("test levels done");
  endtask

  // Each sensing mode of the pin factor: low phase, then high phase
  task automatic t_sense();
    for (int m = 0; m < 4; m++)
    begin
      wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, {16'h0000, 1'b0, m[1:0], 5'b00010, 8'h00});
      @(posedge ref_clk);
      pin <= 1'b0;
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK(irq_req[1], m == 0)
      `CHK(seen_irq[1], m != 3)
      @(posedge ref_clk);
      pin <= 1'b1;
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK(irq_req[1], m == 1)
      `CHK(seen_irq[1], m != 2)
    end
    $display("test sense done");
  endtask

  task automatic t_dma();
    for (int c = 0; c < 8; c++)
    begin
      wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, {16'h0000, 5'b01110, c[2:0], 8'h00});
      pulse_pin();
      `CHK(seen_dma, 8'h01 << c)
      `CHK(seen_irq, 2'b00)
    end
    // Software factor steered to channel 6
    wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, 32'h0000_0016);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    wr(ifc_pkg::SOFT_REQ_ADDR, 32'h0000_0001);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(seen_dma, 8'h40)
    `CHK(seen_irq, 2'b00)
    wr(ifc_pkg::SOFT_REQ_ADDR, 32'h0000_0000);
    $display("test dma done");
  endtask

  task automatic t_soft();
    for (int s = 0; s < 4; s++)
    begin
      wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, {24'h000000, 1'b0, s[1:0], 5'b00101});
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      wr(ifc_pkg::SOFT_REQ_ADDR, 32'h0000_0001);
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(seen_irq, {1'b0, s == 0})
      `CHK(lvl0, (s == 0) ? 3'h5 : 3'h0)
      wr(ifc_pkg::SOFT_REQ_ADDR, 32'h0000_0000);
    end
    $display("test soft done");
  endtask

  task automatic t_irq();
    wr(ifc_pkg::FACTOR_CFG_WORD_0_ADDR, 32'h0000_6300);
    wr(ifc_pkg::IRQ_CLEAR_ADDR, 32'h0000_0003);
    wr(ifc_pkg::IRQ_ENABLE_ADDR, 32'h0000_0002);
    rdw(ifc_pkg::IRQ_ENABLE_ADDR);
    `CHK(rd, 32'h0000_0002)
    pulse_pin();
    rdw(ifc_pkg::IRQ_STATUS_ADDR);
    `CHK(rd, 32'h0000_0002)
    `CHK(irq_out, 1'b1)
    wr(ifc_pkg::IRQ_CLEAR_ADDR, 32'h0000_0002);
    rdw(ifc_pkg::IRQ_STATUS_ADDR);
    `CHK(rd, 32'h0000_0000)
    `CHK(irq_out, 1'b0)
    wr(ifc_pkg::IRQ_ENABLE_ADDR, 32'h0000_0000);
    pulse_pin();
    `CHK(irq_out, 1'b0)
    rdw(ifc_pkg::IRQ_STATUS_ADDR);
    `CHK(rd, 32'h0000_0002)
    $display("test irq done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_levels();
    t_sense();
    t_dma();
    t_soft();
    t_irq();
    end_of_test();
  end

  // The run needs well under 1000 cycles
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
